// [csa_dev.sv]
// Operation
// - All port signals on status clock, sync reset
// - Master gives 16-bit address, strobes, data
// - Read data with one-cycle valid strobe
// - Wait request high except in the one ack cycle; master holds request
// - Fixed counter flags read timeout
// - Master tolerates unbounded read latency; device answers in about 80 cycles, or 200 on a read timeout
// - Back-to-back mixed accesses, one at a time
`default_nettype none
module csa_dev
	import csa_pkg::*;
(
	csa_if.dev bus,
	output logic [15:0] reg_addr,
	output logic reg_we,
	output logic [31:0] reg_wdata,
	output logic reg_re,
	input wire logic [31:0] reg_rdata
);
	csa_state_e state_ff, nxt_state;
	logic [7:0] cnt_ff;
	logic [31:0] rdata_ff;
	logic valid_ff;
	logic wait_ff;
	logic tmo_ff;
	logic [15:0] raddr_ff;
	logic [31:0] wdata_ff;
	logic we_ff;
	logic re_ff;
	logic rd_done;
	logic rd_expire;
	logic take;

	// An access that just ended still shows its strobe while wait is low; only a strobe seen with wait high is new
	assign take = (state_ff == CSA_IDLE) && wait_ff && (bus.read || bus.write);
	// Undefined addresses never answer, so only the watchdog ends them
	assign rd_done = (cnt_ff == CSA_READ_LAT) && csa_addr_ok(raddr_ff);
	assign rd_expire = (cnt_ff == CSA_TIMEOUT);

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			CSA_IDLE:
			begin
				if (take && bus.read)
					nxt_state = CSA_RWAIT;
				else if (take && bus.write)
					nxt_state = CSA_WDONE;
			end
			CSA_RWAIT:
			begin
				if (rd_done || rd_expire)
					nxt_state = CSA_IDLE;
			end
			CSA_WDONE:
				nxt_state = CSA_IDLE;
			default:
				nxt_state = CSA_IDLE;
		endcase
	end

	always_ff @(posedge bus.clock)
	begin
		if (!bus.rst_n)
			state_ff <= CSA_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Wait request is high by default so a new strobe is never taken blind
	always_ff @(posedge bus.clock)
	begin
		if (!bus.rst_n)
			wait_ff <= 1'b1;
		else
			wait_ff <= !(nxt_state == CSA_IDLE && state_ff != CSA_IDLE);
	end

	always_ff @(posedge bus.clock)
	begin
		if (!bus.rst_n)
			cnt_ff <= 8'h00;
		else if (state_ff == CSA_RWAIT)
			cnt_ff <= cnt_ff + 8'h01;
		else
			cnt_ff <= 8'h00;
	end

	always_ff @(posedge bus.clock)
	begin
		if (!bus.rst_n)
		begin
			raddr_ff <= 16'h0000;
			wdata_ff <= CSA_RDATA_RST;
		end
		else if (take)
		begin
			raddr_ff <= bus.addr;
			wdata_ff <= bus.writedata;
		end
	end

	always_ff @(posedge bus.clock)
	begin
		if (!bus.rst_n)
		begin
			we_ff <= 1'b0;
			re_ff <= 1'b0;
		end
		else
		begin
			we_ff <= take && !bus.read && bus.write && csa_addr_ok(bus.addr);
			re_ff <= (state_ff == CSA_RWAIT) && (cnt_ff == CSA_READ_LAT - 8'h01) && csa_addr_ok(raddr_ff);
		end
	end

	always_ff @(posedge bus.clock)
	begin
		if (!bus.rst_n)
		begin
			rdata_ff <= CSA_RDATA_RST;
			valid_ff <= 1'b0;
			tmo_ff <= 1'b0;
		end
		else
		begin
			valid_ff <= (state_ff == CSA_RWAIT) && (rd_done || rd_expire);
			tmo_ff <= (state_ff == CSA_RWAIT) && rd_expire && !rd_done;
			if (state_ff == CSA_RWAIT && rd_done)
				rdata_ff <= reg_rdata;
			else if (state_ff == CSA_RWAIT && rd_expire)
				rdata_ff <= CSA_TIMEOUT_DATA;
		end
	end

	assign bus.readdata = rdata_ff;
	assign bus.readdata_valid = valid_ff;
	assign bus.waitrequest = wait_ff;
	assign bus.read_timeout = tmo_ff;
	assign reg_addr = raddr_ff;
	assign reg_wdata = wdata_ff;
	assign reg_we = we_ff;
	assign reg_re = re_ff;
endmodule
`default_nettype wire

// [csa_pkg.sv]
`default_nettype none
package csa_pkg;
	localparam int CSA_ADDR_W = 16;
	localparam int CSA_DATA_W = 32;
	localparam int CSA_LAT_W = 8;
	// Read latency of the register space behind the port, in status clocks
	localparam logic [7:0] CSA_READ_LAT = 8'h50;
	// Read watchdog, hardwired; well above the normal latency
	localparam logic [7:0] CSA_TIMEOUT = 8'hC8;
	// Top of the implemented register space; reads above it return only the timeout data
	localparam logic [15:0] CSA_ADDR_TOP = 16'h00FF;
	localparam logic [31:0] CSA_RDATA_RST = 32'h0000_0000;
	localparam logic [31:0] CSA_TIMEOUT_DATA = 32'hDEAD_0000;

	typedef enum logic [1:0]
	{
		CSA_IDLE = 2'b00,
		CSA_RWAIT = 2'b01,
		CSA_WDONE = 2'b10
	} csa_state_e;

	function automatic logic csa_addr_ok(input logic [15:0] a);
		return a <= CSA_ADDR_TOP;
	endfunction
endpackage
`default_nettype wire

// [csa_if.sv]
`default_nettype none
interface csa_if
	import csa_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n
);
	logic [15:0] addr;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic readdata_valid;
	logic waitrequest;
	logic read_timeout;

	modport dev
	(
		input clock, rst_n, addr, read, write, writedata,
		output readdata, readdata_valid, waitrequest, read_timeout
	);
	modport mst
	(
		input clock, rst_n, readdata, readdata_valid, waitrequest, read_timeout,
		output addr, read, write, writedata
	);
endinterface
`default_nettype wire

// [csa_mst.sv]
`default_nettype none
module csa_mst
	import csa_pkg::*;
(
	csa_if.mst bus,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [15:0] req_addr,
	input wire logic [31:0] req_wdata,
	output logic req_ready,
	output logic [31:0] rsp_data,
	output logic rsp_valid,
	output logic rsp_timeout
);
	logic [15:0] addr_ff;
	logic rd_ff;
	logic wr_ff;
	logic [31:0] wdata_ff;
	logic rdwait_ff;
	logic [31:0] rsp_data_ff;
	logic rsp_valid_ff;
	logic rsp_tmo_ff;
	logic busy;

	assign busy = rd_ff || wr_ff || rdwait_ff;

	// Request held until wait request drops; no limit on read latency
	always_ff @(posedge bus.clock)
	begin
		if (!bus.rst_n)
		begin
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			rdwait_ff <= 1'b0;
			addr_ff <= 16'h0000;
			wdata_ff <= 32'h0000_0000;
		end
		else if (!busy)
		begin
			if (req_valid)
			begin
				addr_ff <= req_addr;
				wdata_ff <= req_wdata;
				rd_ff <= !req_write;
				wr_ff <= req_write;
			end
		end
		else
		begin
			if (wr_ff && !bus.waitrequest)
				wr_ff <= 1'b0;
			if (rd_ff && !bus.waitrequest)
				rd_ff <= 1'b0;
			if (rd_ff && !bus.waitrequest && !bus.readdata_valid)
				rdwait_ff <= 1'b1;
			if (rdwait_ff && bus.readdata_valid)
				rdwait_ff <= 1'b0;
		end
	end

	always_ff @(posedge bus.clock)
	begin
		if (!bus.rst_n)
		begin
			rsp_data_ff <= 32'h0000_0000;
			rsp_valid_ff <= 1'b0;
			rsp_tmo_ff <= 1'b0;
		end
		else
		begin
			rsp_valid_ff <= bus.readdata_valid && (rd_ff || rdwait_ff);
			rsp_tmo_ff <= bus.readdata_valid && bus.read_timeout;
			if (bus.readdata_valid)
				rsp_data_ff <= bus.readdata;
		end
	end

	assign bus.addr = addr_ff;
	assign bus.read = rd_ff;
	assign bus.write = wr_ff;
	assign bus.writedata = wdata_ff;
	assign req_ready = !busy;
	assign rsp_data = rsp_data_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_timeout = rsp_tmo_ff;
endmodule
`default_nettype wire

// [csa_sva.sv]
`default_nettype none
module csa_sva
	import csa_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] addr,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic readdata_valid,
	input wire logic waitrequest,
	input wire logic read_timeout
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_valid_one_cycle: assert property (readdata_valid |=> !readdata_valid) else $error("valid held");
	chk_valid_ends_wait: assert property (readdata_valid |-> !waitrequest) else $error("valid while busy");
	chk_wait_low_once: assert property (!waitrequest |=> waitrequest) else $error("wait low twice");
	chk_tmo_with_valid: assert property (read_timeout |-> readdata_valid) else $error("lone timeout");
	chk_tmo_data: assert property (read_timeout |-> readdata == CSA_TIMEOUT_DATA) else $error("timeout data");
	chk_write_accept: assert property ($rose(write) |-> ##2 !waitrequest) else $error("write ack");
	chk_ack_needs_req: assert property ((!read && !write) |=> waitrequest) else $error("stray ack");
	chk_read_latency: assert property ($rose(read) && addr <= CSA_ADDR_TOP |-> ##[80:82] (readdata_valid && !read_timeout))
		else $error("read latency");
	chk_read_expiry: assert property ($rose(read) && addr > CSA_ADDR_TOP |-> ##[200:203] read_timeout)
		else $error("no timeout");
endmodule
`default_nettype wire

// [tb_top.sv]
`default_nettype none
module tb_top
	import csa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	logic [31:0] req_wdata = 32'h0000_0000;
	logic req_ready, rsp_valid, rsp_timeout, reg_we, reg_re;
	logic [31:0] rsp_data, reg_wdata;
	logic [15:0] reg_addr;
	logic [31:0] mem [256];
	int error_cnt = 0;
	int compares = 0;
	csa_if bus (.clock(clock), .rst_n(rst_n));
	csa_dev i_csa_dev (.bus(bus), .reg_addr(reg_addr), .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_re(reg_re),
		.reg_rdata(mem[reg_addr[7:0]]));
	csa_mst i_csa_mst (.bus(bus), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
		.rsp_timeout(rsp_timeout));
	csa_sva i_csa_sva (.clock(bus.clock), .rst_n(bus.rst_n), .addr(bus.addr), .read(bus.read), .write(bus.write),
		.readdata(bus.readdata), .readdata_valid(bus.readdata_valid), .waitrequest(bus.waitrequest),
		.read_timeout(bus.read_timeout));
	// Register space stand-in; unwritten words read unknown, so only written words are read back
	always @(posedge clock) if (reg_we) mem[reg_addr[7:0]] <= reg_wdata;
	initial forever #25 clock = ~clock;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic tmo);
		int n;
		@(posedge clock);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		do @(posedge clock); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		if (!w)
		begin
			n = 0;
			do
			begin
				@(posedge clock);
				n++;
			end
			while (rsp_valid !== 1'b1 && n < 300);
			chk(rsp_data, d);
			chk(rsp_timeout, tmo);
			chk(bus.readdata, d);
		end
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		print_verdict;
	end
	initial
	begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		acc(1'h1, 16'h0010, 32'hA5A5_0001, 1'h0);
		acc(1'h0, 16'h0010, 32'hA5A5_0001, 1'h0);
		acc(1'h1, 16'h00FF, 32'h1234_5678, 1'h0);
		acc(1'h0, 16'h00FF, 32'h1234_5678, 1'h0);
		$display("test done: write read write");
		acc(1'h0, 16'h0100, CSA_TIMEOUT_DATA, 1'h1);
		$display("test done: read timeout");
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		chk(bus.waitrequest, 1'h1);
		chk(bus.readdata, CSA_RDATA_RST);
		rst_n <= 1'b1;
		acc(1'h0, 16'h0010, 32'hA5A5_0001, 1'h0);
		$display("test done: reset");
		print_verdict;
	end
endmodule
`default_nettype wire
